// [hdl/sep_core.sv]
// Serial command port of a 4096-bit nonvolatile memory
`timescale 1ns/1ps
`include "sep_defs.svh"
// How it works
// (R1) Strap high selects 256x16, strap low selects 512x8.
// (R2) Serial input bits are sampled on each rising serial clock edge.
// (R3) Start bit one, 4-bit opcode, then 8 or 9 address bits.
// (R4) Write-type instructions append 16 or 8 data bits.
// (R5) Data output floats except while read data is returned.
// (R6) Read drives one dummy zero, then the word's data bits.
// (R7) Read output bit changes on each rising serial clock edge.
// (R8) Opcode 1000 reads the addressed word.
// (R9) Programming is disabled after power-up.
// (R10) Unlock opcode 0011 enables programming until lock or power loss.
// (R11) Lock opcode 0000 blocks all program and erase functions.
// (R12) Reads work whether programming is enabled or not.
// (R13) Opcode X100 programs one word; busy goes low after data.
// (R14) Self-timed cycles finish without further serial clocks.
// (R15) Host polls ready/busy to see the cycle end.
// (R16) Opcode 0010 erases whole array to ones, busy low.
// (R17) Opcode 0001 stores one word into every location.
// (R18) Self-timed cycle lasts at most 10 ms.
// (R19) Deselect ignores inputs, floats output, drops partial instruction.
// (R20) Ready/busy is high when idle, low only during a cycle.
// (R21) Read data leaves most significant bit first.
module sep_core #(
  parameter int PROG_CYCLES = `SEP_PROG_CYCLES
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // Serial pins
  input wire logic i_sel,
  input wire logic i_sclk,
  input wire logic i_serial_in,
  input wire logic i_word_width_strap,
  output logic o_serial_out,
  output logic o_serial_out_oe,
  output logic o_ready
);
  sep_pkg::sep_pins_s pins;
  sep_pkg::sep_pins_s pins_raw;
  sep_pkg::sep_state_e state_reg;
  sep_pkg::sep_job_e job_reg;
  logic sclk_d_reg;
  logic rise;
  logic strap_reg;
  logic strap_pin;
  logic unlocked_reg;
  logic [3:0] op_reg;
  logic [8:0] addr_reg;
  logic [15:0] data_reg;
  logic [15:0] shift_reg;
  logic [4:0] cnt_reg;
  logic [31:0] timer_reg;
  logic [8:0] addr_bits;
  logic [4:0] data_bits;
  logic [7:0] mem [0:`SEP_CELLS-1];
  logic [8:0] wr_ptr_reg;
  logic [15:0] rd_word;
  logic is_write;
  logic is_prog;

  assign pins_raw = '{sel: i_sel, clk: i_sclk, din: i_serial_in};

  // Pin synchronisers
  sep_sync #(
    .WIDTH(3)
  ) u_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_async(pins_raw),
    .o_level(pins)
  );

  // Strap synchroniser
  sep_sync #(
    .WIDTH(1)
  ) u_strap_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_async(i_word_width_strap),
    .o_level(strap_pin)
  );

  // Widths by organisation (strap high = word mode)
  // (R1) organisation select
  assign addr_bits = strap_reg ? `SEP_ADDR_BITS_WORD : `SEP_ADDR_BITS_BYTE;
  assign data_bits = strap_reg ? `SEP_DATA_BITS_WORD : `SEP_DATA_BITS_BYTE;
  // (R13) first opcode bit ignored
  assign is_prog = (op_reg[2:0] == `SEP_OP_PROG);
  assign is_write = is_prog || (op_reg == `SEP_OP_FILL);
  assign rise = pins.clk && !sclk_d_reg;
  assign rd_word = strap_reg ? {mem[{addr_reg[7:0], 1'b1}], mem[{addr_reg[7:0], 1'b0}]}
                             : {8'h00, mem[addr_reg]};

  // Serial clock edge detect
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      sclk_d_reg <= 1'b0;
    else if (i_ce)
      sclk_d_reg <= pins.clk;
  end

  // Strap caught while deselected
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      strap_reg <= 1'b1;
    else if (i_ce && !pins.sel && state_reg != sep_pkg::ST_WAIT)
      strap_reg <= strap_pin;
  end

  // Command sequencer
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state_reg <= sep_pkg::ST_IDLE;
      op_reg <= 4'h0;
      addr_reg <= 9'h000;
      data_reg <= 16'h0000;
      shift_reg <= 16'h0000;
      cnt_reg <= 5'd0;
      timer_reg <= 32'd0;
      job_reg <= sep_pkg::JOB_WORD;
      unlocked_reg <= 1'b0;
      o_serial_out <= 1'b0;
      o_serial_out_oe <= 1'b0;
      o_ready <= 1'b1;
    end
    else if (i_ce)
    begin
      // (R19) deselect aborts a partial instruction
      if (!pins.sel && state_reg != sep_pkg::ST_WAIT)
      begin
        state_reg <= sep_pkg::ST_IDLE;
        o_serial_out_oe <= 1'b0;
        o_serial_out <= 1'b0;
      end
      else
      begin
        case (state_reg)
          sep_pkg::ST_IDLE:
          begin
            // (R3) start bit detect
            if (rise && pins.din)
            begin
              state_reg <= sep_pkg::ST_OPCODE;
              cnt_reg <= 5'd0;
            end
          end
          sep_pkg::ST_OPCODE:
          begin
            // (R2) sample on rising edge
            if (rise)
            begin
              op_reg <= {op_reg[2:0], pins.din};
              if (cnt_reg == 5'(`SEP_OP_BITS - 1))
              begin
                cnt_reg <= 5'd0;
                state_reg <= sep_pkg::ST_ADDR;
              end
              else
                cnt_reg <= cnt_reg + 5'd1;
            end
          end
          sep_pkg::ST_ADDR:
          begin
            if (rise)
            begin
              addr_reg <= strap_reg ? {1'b0, addr_reg[6:0], pins.din}
                                    : {addr_reg[7:0], pins.din};
              if (cnt_reg == 5'(addr_bits - 9'd1))
              begin
                cnt_reg <= 5'd0;
                // (R8) read: load word, drive dummy zero
                if (op_reg == `SEP_OP_READ)
                begin
                  state_reg <= sep_pkg::ST_READ;
                  // (R6) dummy zero bit
                  o_serial_out_oe <= 1'b1;
                  o_serial_out <= 1'b0;
                end
                // (R4) write-type takes data
                else if (is_write)
                  state_reg <= sep_pkg::ST_DATA;
                // (R10) unlock
                else if (op_reg == `SEP_OP_UNLOCK)
                begin
                  unlocked_reg <= 1'b1;
                  state_reg <= sep_pkg::ST_IDLE;
                end
                // (R11) lock
                else if (op_reg == `SEP_OP_LOCK)
                begin
                  unlocked_reg <= 1'b0;
                  state_reg <= sep_pkg::ST_IDLE;
                end
                // (R16) bulk erase, (R9) only when unlocked
                else if (op_reg == `SEP_OP_ERASE && unlocked_reg)
                begin
                  job_reg <= sep_pkg::JOB_ERASE;
                  timer_reg <= 32'd0;
                  o_ready <= 1'b0;
                  state_reg <= sep_pkg::ST_WAIT;
                end
                else
                  state_reg <= sep_pkg::ST_IDLE;
              end
              else
                cnt_reg <= cnt_reg + 5'd1;
            end
          end
          sep_pkg::ST_DATA:
          begin
            if (rise)
            begin
              data_reg <= {data_reg[14:0], pins.din};
              if (cnt_reg == data_bits - 5'd1)
              begin
                cnt_reg <= 5'd0;
                // (R13) (R17) start self-timed cycle when unlocked
                if (unlocked_reg)
                begin
                  job_reg <= is_prog ? sep_pkg::JOB_WORD : sep_pkg::JOB_FILL;
                  timer_reg <= 32'd0;
                  o_ready <= 1'b0;
                  state_reg <= sep_pkg::ST_WAIT;
                end
                else
                  state_reg <= sep_pkg::ST_IDLE;
              end
              else
                cnt_reg <= cnt_reg + 5'd1;
            end
          end
          sep_pkg::ST_READ:
          begin
            // Load the word once the last address bit is in
            if (!rise && cnt_reg == 5'd0)
              shift_reg <= strap_reg ? rd_word : {rd_word[7:0], 8'h00};
            // (R7) (R21) next bit MSB first on each rising edge, (R12) no lock check
            if (rise)
            begin
              if (cnt_reg == data_bits)
              begin
                // (R5) float after the last bit
                o_serial_out_oe <= 1'b0;
                o_serial_out <= 1'b0;
                state_reg <= sep_pkg::ST_IDLE;
              end
              else
              begin
                o_serial_out <= shift_reg[15];
                shift_reg <= {shift_reg[14:0], 1'b0};
                cnt_reg <= cnt_reg + 5'd1;
              end
            end
          end
          sep_pkg::ST_WAIT:
          begin
            // (R14) (R15) (R18) (R20) self-timed, ready high at end
            if (timer_reg == 32'(PROG_CYCLES - 1))
            begin
              o_ready <= 1'b1;
              state_reg <= sep_pkg::ST_IDLE;
            end
            else
              timer_reg <= timer_reg + 32'd1;
          end
          default:
            state_reg <= sep_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // Array update pointer for bulk jobs
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      wr_ptr_reg <= 9'h000;
    else if (i_ce)
    begin
      if (state_reg != sep_pkg::ST_WAIT)
        wr_ptr_reg <= 9'h000;
      else if (wr_ptr_reg != 9'h1ff)
        wr_ptr_reg <= wr_ptr_reg + 9'h001;
    end
  end

  // Array storage
  always_ff @(posedge i_clk)
  begin
    if (i_ce && state_reg == sep_pkg::ST_WAIT)
    begin
      case (job_reg)
        sep_pkg::JOB_WORD:
        begin
          if (timer_reg == 32'd0)
          begin
            if (strap_reg)
            begin
              mem[{addr_reg[7:0], 1'b1}] <= data_reg[15:8];
              mem[{addr_reg[7:0], 1'b0}] <= data_reg[7:0];
            end
            else
              mem[addr_reg] <= data_reg[7:0];
          end
        end
        // (R16) erase to ones
        sep_pkg::JOB_ERASE:
          mem[wr_ptr_reg] <= `SEP_ERASED;
        // (R17) fill every location
        default:
          mem[wr_ptr_reg] <= (strap_reg && wr_ptr_reg[0]) ? data_reg[15:8] : data_reg[7:0];
      endcase
    end
  end
endmodule

// [hdl/sep_defs.svh]
// Constants for the serial memory command port
`ifndef SEP_DEFS_SVH
`define SEP_DEFS_SVH
`define SEP_OP_READ 4'h8
`define SEP_OP_PROG 3'h4
`define SEP_OP_UNLOCK 4'h3
`define SEP_OP_LOCK 4'h0
`define SEP_OP_ERASE 4'h2
`define SEP_OP_FILL 4'h1
`define SEP_OP_BITS 4
`define SEP_ADDR_BITS_WORD 9'd8
`define SEP_ADDR_BITS_BYTE 9'd9
`define SEP_DATA_BITS_WORD 5'd16
`define SEP_DATA_BITS_BYTE 5'd8
`define SEP_CELLS 512
`define SEP_ERASED 8'hff
`define SEP_CLK_HZ 10000000
`define SEP_PROG_TIME_MS 10
`define SEP_PROG_CYCLES ((`SEP_CLK_HZ / 1000) * `SEP_PROG_TIME_MS)
`endif

// [hdl/sep_pkg.sv]
// Types for the serial memory command port
package sep_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OPCODE,
    ST_ADDR,
    ST_DATA,
    ST_READ,
    ST_WAIT
  } sep_state_e;

  typedef struct packed {
    logic sel;
    logic clk;
    logic din;
  } sep_pins_s;

  typedef enum logic [1:0] {
    JOB_WORD,
    JOB_ERASE,
    JOB_FILL
  } sep_job_e;
endpackage

// [hdl/sep_sync.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module sep_sync #(
  parameter int WIDTH = 3
) (
  // Clock and control
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // Data
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  // Stages
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end
    else if (i_ce)
    begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Accept a change once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge i_clk)
      begin
        if (i_reset)
          o_level[g] <= 1'b0;
        else if (i_ce && (s2_reg[g] == s3_reg[g]))
          o_level[g] <= s3_reg[g];
      end
    end
  endgenerate
endmodule

// [sim/sep_core_bench.sv]
// Self-checking bench for the serial memory command port
`timescale 1ns/1ps
module sep_core_bench;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_ce = 1'b1;
  logic strap = 1'b1;
  logic sel;
  logic sclk;
  logic din;
  logic dout;
  logic oe;
  logic rdy;
  logic [16:0] rd;
  int n_fail = 0;
  int checked = 0;
  always #50 i_clk = ~i_clk;
  sep_core #(.PROG_CYCLES(600)) sep_core_inst (.i_clk(i_clk), .i_reset(i_reset),
    .i_ce(i_ce), .i_sel(sel), .i_sclk(sclk), .i_serial_in(din),
    .i_word_width_strap(strap), .o_serial_out(dout), .o_serial_out_oe(oe), .o_ready(rdy));
  sep_host sep_host_inst (.i_clk(i_clk), .o_sel(sel), .o_sclk(sclk), .o_din(din),
    .i_dout(dout), .i_dout_oe(oe));
  task automatic final_report();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
    begin
      $display("== PASSED ==");
    end
    else
    begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmd(input logic [3:0] op, input logic [8:0] a, input logic [15:0] d,
    input int nr);
    int na;
    int nd;
    logic [31:0] v;
    na = strap ? 8 : 9;
    nd = (op[2:0] == 3'h4 || op == 4'h1) ? (strap ? 16 : 8) : 0;
    v = 32'h0000_0010 | op;
    v = (v << na) | a;
    v = (v << nd) | d;
    sep_host_inst.frame(v, 5 + na + nd, nr, rd);
  endtask
  task automatic poll(input logic busy);
    int n;
    chk("busy", {16'h0000, busy}, {16'h0000, !rdy});
    n = 0;
    while (rdy !== 1'b1 && n < 700)
    begin
      sep_host_inst.tick(1);
      n++;
    end
    if (n == 700)
    begin
      n_fail++;
      $display("ERROR ready expected 1 seen %b", rdy);
      final_report();
    end
  endtask
  task automatic do_reset();
    i_reset = 1'b1;
    sep_host_inst.tick(3);
    i_reset = 1'b0;
    sep_host_inst.tick(8);
  endtask
  task automatic t_locked();
    cmd(4'hC, 9'h012, 16'h0000, 0);
    poll(1'b0);
  endtask
  task automatic t_erase();
    cmd(4'h3, 9'h000, 16'h0000, 0);
    cmd(4'h2, 9'h000, 16'h0000, 0);
    poll(1'b1);
    cmd(4'h8, 9'h012, 16'h0000, 16);
    chk("erased", 17'h0_FFFF, rd);
  endtask
  task automatic t_program();
    cmd(4'hC, 9'h012, 16'hA5C3, 0);
    i_ce = 1'b0;
    sep_host_inst.tick(650);
    i_ce = 1'b1;
    poll(1'b1);
    cmd(4'h8, 9'h012, 16'h0000, 16);
    chk("word", 17'h0_A5C3, rd);
  endtask
  task automatic t_fill();
    cmd(4'h1, 9'h000, 16'h3C96, 0);
    poll(1'b1);
    cmd(4'h8, 9'h000, 16'h0000, 16);
    chk("fill lo", 17'h0_3C96, rd);
    cmd(4'h8, 9'h0FF, 16'h0000, 16);
    chk("fill hi", 17'h0_3C96, rd);
  endtask
  task automatic t_lock();
    cmd(4'h0, 9'h000, 16'h0000, 0);
    cmd(4'h4, 9'h012, 16'h0000, 0);
    poll(1'b0);
    cmd(4'h2, 9'h000, 16'h0000, 0);
    poll(1'b0);
    cmd(4'h8, 9'h012, 16'h0000, 16);
    chk("locked read", 17'h0_3C96, rd);
  endtask
  task automatic t_byte();
    strap = 1'b0;
    sep_host_inst.ph = 12;
    sep_host_inst.tick(8);
    cmd(4'h8, 9'h025, 16'h0000, 8);
    chk("byte", 17'h0_003C, rd);
    cmd(4'h3, 9'h000, 16'h0000, 0);
    cmd(4'h4, 9'h1FF, 16'h005A, 0);
    poll(1'b1);
    cmd(4'h8, 9'h1FF, 16'h0000, 8);
    chk("byte prog", 17'h0_005A, rd);
  endtask
  task automatic t_abort();
    cmd(4'h8, 9'h1FF, 16'h0000, 3);
    chk("float", 17'h0_0000, {16'h0000, oe});
    sep_host_inst.frame(32'h0000_0014, 5, 0, rd);
    poll(1'b0);
    cmd(4'h8, 9'h1FF, 16'h0000, 8);
    chk("after abort", 17'h0_005A, rd);
  endtask
  initial
  begin
    do_reset();
    t_locked();
    t_erase();
    t_program();
    t_fill();
    t_lock();
    t_byte();
    t_abort();
    do_reset();
    chk("reset pins", 17'h0_0001, {15'h0000, oe, rdy});
    t_locked();
    final_report();
  end
endmodule

// [sim/sep_core_monitor.sv]
// Pin-level assertions for the serial memory command port
`timescale 1ns/1ps
module sep_core_monitor #(
  parameter int PROG_CYCLES = 600
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // Serial pins
  input wire logic i_sel,
  input wire logic i_sclk,
  input wire logic i_serial_in,
  input wire logic i_word_width_strap,
  input wire logic o_serial_out,
  input wire logic o_serial_out_oe,
  input wire logic o_ready
);
  int busy_cnt;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  // Length of the busy phase
  always_ff @(posedge i_clk)
  begin
    if (i_reset || o_ready)
    begin
      busy_cnt <= 0;
    end
    else if (i_ce)
    begin
      busy_cnt <= busy_cnt + 1;
    end
  end
  property p_quiet_low;
    !o_serial_out_oe |-> !o_serial_out;
  endproperty
  a_quiet_low: assert property (p_quiet_low)
    else $error("data out high while not driven");
  property p_desel_float;
    !i_sel [*8] |-> !o_serial_out_oe;
  endproperty
  a_desel_float: assert property (p_desel_float)
    else $error("data out driven while deselected");
  property p_first_zero;
    $rose(o_serial_out_oe) |-> !o_serial_out;
  endproperty
  a_first_zero: assert property (p_first_zero)
    else $error("first read bit not zero");
  property p_bit_on_high;
    o_serial_out_oe && $past(o_serial_out_oe) && $changed(o_serial_out) |-> i_sclk;
  endproperty
  a_bit_on_high: assert property (p_bit_on_high)
    else $error("read bit changed without clock rise");
  property p_busy_len;
    $rose(o_ready) |-> busy_cnt >= PROG_CYCLES - 1 && busy_cnt <= PROG_CYCLES + 1;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy length wrong");
  property p_busy_cap;
    busy_cnt <= PROG_CYCLES + 1;
  endproperty
  a_busy_cap: assert property (p_busy_cap)
    else $error("busy too long");
  property p_busy_quiet;
    !o_ready |-> !o_serial_out_oe;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("data out driven while busy");
  property p_reset_state;
    $past(i_reset) |-> o_ready && !o_serial_out_oe;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("wrong state after reset");
  c_read: cover property ($rose(o_serial_out_oe));
  c_busy: cover property ($fell(o_ready));
  c_abort: cover property (!i_sel && o_serial_out_oe);
endmodule
bind sep_core sep_core_monitor #(.PROG_CYCLES(PROG_CYCLES)) sep_core_monitor_inst (
  .i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_sel(i_sel), .i_sclk(i_sclk),
  .i_serial_in(i_serial_in), .i_word_width_strap(i_word_width_strap),
  .o_serial_out(o_serial_out), .o_serial_out_oe(o_serial_out_oe), .o_ready(o_ready));

// [sim/sep_host.sv]
// Host controller model for the serial command pins
`timescale 1ns/1ps
module sep_host (
  // Clock
  input wire logic i_clk,
  // Device pins
  output logic o_sel,
  output logic o_sclk,
  output logic o_din,
  input wire logic i_dout,
  input wire logic i_dout_oe
);
  int ph = 8;
  initial
  begin
    o_sel = 1'b0;
    o_sclk = 1'b0;
    o_din = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic frame(input logic [31:0] v, input int n, input int nr, output logic [16:0] rd);
    rd = '0;
    o_sel = 1'b1;
    tick(ph);
    for (int i = n - 1; i >= 0; i--)
    begin
      o_din = v[i];
      tick(ph);
      o_sclk = 1'b1;
      tick(ph);
      o_sclk = 1'b0;
    end
    rd = {rd[15:0], i_dout | !i_dout_oe};
    for (int i = 0; i < nr; i++)
    begin
      tick(ph);
      o_sclk = 1'b1;
      tick(ph);
      rd = {rd[15:0], i_dout | !i_dout_oe};
      o_sclk = 1'b0;
    end
    tick(ph);
    o_sel = 1'b0;
    o_din = !o_din;
    tick(ph);
  endtask
endmodule
